/* File: shared/scp_pkg.sv */
// Shared constants of the slave control port: register map, fields, timing.
package scp_pkg;

	// ************************************************************
	// Register bus geometry.
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0] IDX_DATA_LATCH = 10'h008;
	localparam logic [9:0] IDX_CTRL_PORT = 10'h009;
	localparam logic [9:0] IDX_DATA_DIR = 10'h088;
	localparam logic [9:0] IDX_DIR_STATUS = 10'h089;
	localparam logic [9:0] IDX_ANALOG_CFG = 10'h09f;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h0a0;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h0a1;

	// ************************************************************
	// Fields of the direction and status register.
	// ************************************************************
	localparam int BIT_IN_FULL = 7;
	localparam int BIT_OUT_FULL = 6;
	localparam int BIT_IN_OVF = 5;
	localparam int BIT_MODE = 4;
	localparam int DIR_MSB = 2;

	// Control pin positions.
	localparam int PIN_RD = 0;
	localparam int PIN_WR = 1;
	localparam int PIN_CS = 2;

	// Interrupt status bit positions.
	localparam int EVT_WRITTEN = 0;
	localparam int EVT_READ = 1;
	localparam int EVT_OVF = 2;

	// ************************************************************
	// Reset values.
	// ************************************************************
	localparam logic [7:0] RST_DATA_DIR = 8'hff;
	localparam logic [2:0] RST_CTRL_DIR = 3'h7;
	localparam logic [2:0] RST_ANALOG = 3'h7;
	localparam logic [7:0] RST_LATCH = 8'h00;

	// ************************************************************
	// Timing of the external master's strobes.
	// ************************************************************
	localparam int CLK_NS = 10;
	localparam int STROBE_NS = 80;
	localparam int GAP_NS = 30;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;

	// Host sequencer states.
	typedef enum logic [1:0] {
		SCP_IDLE,
		SCP_SELECT,
		SCP_STROBE,
		SCP_GAP
	} scp_host_state_t;

endpackage

/* File: shared/scp_link_if.sv */
// Pin-level link between the slave control port and the external master.
`timescale 1ns/100ps
interface scp_link_if;
	logic [2:0] ctrlDevOut;
	logic [2:0] ctrlDevOe;
	logic [2:0] ctrlHostOut;
	logic [2:0] ctrlHostOe;
	logic [7:0] dataDevOut;
	logic [7:0] dataDevOe;
	logic [7:0] dataHostOut;
	logic [7:0] dataHostOe;
	logic [2:0] ctrlLevel;
	logic [7:0] dataLevel;

	// Wire levels: the device wins, then the host, else a pull-up.
	assign ctrlLevel = (ctrlDevOe & ctrlDevOut)
		| (~ctrlDevOe & ctrlHostOe & ctrlHostOut)
		| (~ctrlDevOe & ~ctrlHostOe);
	assign dataLevel = (dataDevOe & dataDevOut)
		| (~dataDevOe & dataHostOe & dataHostOut)
		| (~dataDevOe & ~dataHostOe);

	modport device (
		input ctrlLevel,
		input dataLevel,
		output ctrlDevOut,
		output ctrlDevOe,
		output dataDevOut,
		output dataDevOe
	);

	modport host (
		input ctrlLevel,
		input dataLevel,
		output ctrlHostOut,
		output ctrlHostOe,
		output dataHostOut,
		output dataHostOe
	);
endinterface

/* File: rtl/scp_host_end.sv */
// External master end: drives strobes and data to the slave control port.
`timescale 1ns/100ps
module scp_host_end #(
	parameter int STROBE_CYCLES = scp_pkg::STROBE_CYC,
	parameter int GAP_CYCLES = scp_pkg::GAP_CYC
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [7:0] reqData,
	output logic reqReady,
	output logic rspValid,
	output logic [7:0] rspData,
	scp_link_if.host link
);

	scp_pkg::scp_host_state_t state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic isWrite_r, isWrite_nxt;
	logic [7:0] wrData_r, wrData_nxt;
	logic [7:0] rdData_r, rdData_nxt;
	logic rspValid_r, rspValid_nxt;
	logic [7:0] dataSync1_r, dataSync2_r;

	// ************************************************************
	// Read data crosses in from the pins through two flip-flops.
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			dataSync1_r <= 8'h00;
			dataSync2_r <= 8'h00;
		end else begin
			dataSync1_r <= link.dataLevel;
			dataSync2_r <= dataSync1_r;
		end
	end

	// ************************************************************
	// Sequencer: select, strobe held long enough, then a gap.
	// ************************************************************
	// The strobe stays low for a whole STROBE_CYCLES so that the
	// device's synchronisers see it and read data has settled.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		isWrite_nxt = isWrite_r;
		wrData_nxt = wrData_r;
		rdData_nxt = rdData_r;
		rspValid_nxt = 1'b0;
		case (state_r)
			scp_pkg::SCP_IDLE: begin
				if (reqValid) begin
					isWrite_nxt = reqWrite;
					wrData_nxt = reqData;
					state_nxt = scp_pkg::SCP_SELECT;
				end
			end
			scp_pkg::SCP_SELECT: begin
				cnt_nxt = 8'(STROBE_CYCLES - 1);
				state_nxt = scp_pkg::SCP_STROBE;
			end
			scp_pkg::SCP_STROBE: begin
				if (cnt_r == 8'h00) begin
					if (!isWrite_r) begin
						rdData_nxt = dataSync2_r;
						rspValid_nxt = 1'b1;
					end
					cnt_nxt = 8'(GAP_CYCLES);
					state_nxt = scp_pkg::SCP_GAP;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			scp_pkg::SCP_GAP: begin
				if (cnt_r == 8'h00) begin
					state_nxt = scp_pkg::SCP_IDLE;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			default: begin
				state_nxt = scp_pkg::SCP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= scp_pkg::SCP_IDLE;
			cnt_r <= 8'h00;
			isWrite_r <= 1'b0;
			wrData_r <= 8'h00;
			rdData_r <= 8'h00;
			rspValid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			isWrite_r <= isWrite_nxt;
			wrData_r <= wrData_nxt;
			rdData_r <= rdData_nxt;
			rspValid_r <= rspValid_nxt;
		end
	end

	// ************************************************************
	// Pin drive: chip select active low framing the strobe.
	// ************************************************************
	logic selected, strobing;
	assign selected = (state_r == scp_pkg::SCP_SELECT)
		|| (state_r == scp_pkg::SCP_STROBE);
	assign strobing = (state_r == scp_pkg::SCP_STROBE);
	assign link.ctrlHostOe = 3'h7;
	assign link.ctrlHostOut[scp_pkg::PIN_CS] = ~selected;
	assign link.ctrlHostOut[scp_pkg::PIN_RD] = ~(strobing && !isWrite_r);
	assign link.ctrlHostOut[scp_pkg::PIN_WR] = ~(strobing && isWrite_r);
	assign link.dataHostOut = wrData_r;
	assign link.dataHostOe = {8{selected && isWrite_r}};

	assign reqReady = (state_r == scp_pkg::SCP_IDLE);
	assign rspValid = rspValid_r;
	assign rspData = rdData_r;

endmodule

/* File: rtl/scp_device_end.sv */
// Device end: control pins, slave-port latches and their APB registers.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
// Contract
// - Three control pins, each with direction bit.
// - Mode bit makes pins read, write, select.
// - Software sets direction bits to inputs first.
// - Software sets analog config to digital.
// - Analog-selected pin reads back as zero.
// - Direction bits act even on analog pins.
// - After reset all control pins are analog.
// - Read strobe low with select: master reads.
// - Write strobe low with select: master writes.
// - Chip select active low gates strobes.
// - Reset clears flags, mode; directions set.
// - Write happens at first joint low detection.
// - Read happens at first joint low detection.
module scp_device_end (
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [scp_pkg::ADDR_W-1:0] paddr,
	input wire logic [scp_pkg::DATA_W-1:0] pwdata,
	output logic [scp_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	scp_link_if.device link
);

	logic [7:0] outLatch_r, outLatch_nxt;
	logic [7:0] inLatch_r, inLatch_nxt;
	logic [7:0] dataDir_r, dataDir_nxt;
	logic [2:0] ctrlDir_r, ctrlDir_nxt;
	logic [2:0] ctrlOut_r, ctrlOut_nxt;
	logic [2:0] analog_r, analog_nxt;
	logic mode_r, mode_nxt;
	logic inFull_r, inFull_nxt;
	logic outFull_r, outFull_nxt;
	logic inOvf_r, inOvf_nxt;
	logic [2:0] irqStat_r, irqStat_nxt;
	logic [2:0] irqMask_r, irqMask_nxt;
	logic [31:0] rdData_r, rdData_nxt;
	logic errHit_r, errHit_nxt;
	logic wrSeen_r, rdSeen_r;
	logic [2:0] ctrlSync1_r, ctrlSync2_r;
	logic [7:0] dataSync1_r, dataSync2_r;

	// ************************************************************
	// Pin synchronisers: two flip-flops before any logic.
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrlSync1_r <= 3'h7;
			ctrlSync2_r <= 3'h7;
			dataSync1_r <= 8'h00;
			dataSync2_r <= 8'h00;
		end else begin
			ctrlSync1_r <= link.ctrlLevel;
			ctrlSync2_r <= ctrlSync1_r;
			dataSync1_r <= link.dataLevel;
			dataSync2_r <= dataSync1_r;
		end
	end

	// ************************************************************
	// Strobe decode.
	// ************************************************************
	logic [2:0] ctrlSeen;
	logic selAct, wrAct, rdAct, wrEvt, rdEvt;
	// A pin in analog mode reads zero, so software must clear the
	// analog bits before entering slave mode or strobes look active.
	assign ctrlSeen = ctrlSync2_r & ~analog_r;
	assign selAct = mode_r && !ctrlSeen[scp_pkg::PIN_CS];
	assign wrAct = selAct && !ctrlSeen[scp_pkg::PIN_WR];
	assign rdAct = selAct && !ctrlSeen[scp_pkg::PIN_RD];
	assign wrEvt = wrAct && !wrSeen_r;
	assign rdEvt = rdAct && !rdSeen_r;

	always_ff @(posedge clock) begin
		if (srst) begin
			wrSeen_r <= 1'b0;
			rdSeen_r <= 1'b0;
		end else begin
			wrSeen_r <= wrAct;
			rdSeen_r <= rdAct;
		end
	end

	// ************************************************************
	// APB decode: one access cycle, read data captured in setup.
	// ************************************************************
	logic setup, access, wrAcc, rdAcc;
	logic [9:0] idx;
	logic mapped;
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign idx = paddr[11:2];
	assign mapped = (paddr[1:0] == 2'b00) && ((idx == scp_pkg::IDX_DATA_LATCH)
		|| (idx == scp_pkg::IDX_CTRL_PORT) || (idx == scp_pkg::IDX_DATA_DIR)
		|| (idx == scp_pkg::IDX_DIR_STATUS) || (idx == scp_pkg::IDX_ANALOG_CFG)
		|| (idx == scp_pkg::IDX_IRQ_STATUS) || (idx == scp_pkg::IDX_IRQ_MASK));
	assign wrAcc = access && pwrite && mapped;
	assign rdAcc = access && !pwrite && mapped;

	logic [7:0] statusView;
	assign statusView = {inFull_r, outFull_r, inOvf_r, mode_r,
		1'b0, ctrlDir_r};

	// Read mux, sampled in the setup cycle so prdata is a flip-flop.
	always_comb begin
		rdData_nxt = rdData_r;
		errHit_nxt = errHit_r;
		if (setup) begin
			errHit_nxt = !mapped;
			rdData_nxt = 32'h0000_0000;
			case (idx)
				scp_pkg::IDX_DATA_LATCH: begin
					rdData_nxt[7:0] = mode_r ? inLatch_r : dataSync2_r;
				end
				scp_pkg::IDX_CTRL_PORT: begin
					rdData_nxt[2:0] = ctrlSeen;
				end
				scp_pkg::IDX_DATA_DIR: begin
					rdData_nxt[7:0] = dataDir_r;
				end
				scp_pkg::IDX_DIR_STATUS: begin
					rdData_nxt[7:0] = statusView;
				end
				scp_pkg::IDX_ANALOG_CFG: begin
					rdData_nxt[2:0] = analog_r;
				end
				scp_pkg::IDX_IRQ_STATUS: begin
					rdData_nxt[2:0] = irqStat_r;
				end
				scp_pkg::IDX_IRQ_MASK: begin
					rdData_nxt[2:0] = irqMask_r;
				end
				default: begin
					rdData_nxt = 32'h0000_0000;
				end
			endcase
			if (paddr[1:0] != 2'b00) begin
				rdData_nxt = 32'h0000_0000;
			end
		end
	end

	// ************************************************************
	// Register and flag state.
	// ************************************************************
	// Sets come last so a set wins over a clear in the same cycle;
	// a fresh output word is never lost to a racing master read.
	always_comb begin
		outLatch_nxt = outLatch_r;
		inLatch_nxt = inLatch_r;
		dataDir_nxt = dataDir_r;
		ctrlDir_nxt = ctrlDir_r;
		ctrlOut_nxt = ctrlOut_r;
		analog_nxt = analog_r;
		mode_nxt = mode_r;
		inFull_nxt = inFull_r;
		outFull_nxt = outFull_r;
		inOvf_nxt = inOvf_r;
		irqStat_nxt = irqStat_r;
		irqMask_nxt = irqMask_r;
		if (wrAcc) begin
			case (idx)
				scp_pkg::IDX_DATA_LATCH: begin
					outLatch_nxt = pwdata[7:0];
					outFull_nxt = mode_r;
				end
				scp_pkg::IDX_CTRL_PORT: begin
					ctrlOut_nxt = pwdata[2:0];
				end
				scp_pkg::IDX_DATA_DIR: begin
					dataDir_nxt = pwdata[7:0];
				end
				scp_pkg::IDX_DIR_STATUS: begin
					ctrlDir_nxt = pwdata[scp_pkg::DIR_MSB:0];
					mode_nxt = pwdata[scp_pkg::BIT_MODE];
					inOvf_nxt = inOvf_r && pwdata[scp_pkg::BIT_IN_OVF];
				end
				scp_pkg::IDX_ANALOG_CFG: begin
					analog_nxt = pwdata[2:0];
				end
				scp_pkg::IDX_IRQ_MASK: begin
					irqMask_nxt = pwdata[2:0];
				end
				default: begin
					irqMask_nxt = irqMask_r;
				end
			endcase
		end
		if (rdAcc && idx == scp_pkg::IDX_DATA_LATCH && mode_r) begin
			inFull_nxt = 1'b0;
		end
		if (rdAcc && idx == scp_pkg::IDX_IRQ_STATUS) begin
			irqStat_nxt = irqStat_r & ~rdData_r[2:0];
		end
		if (wrEvt) begin
			inLatch_nxt = dataSync2_r;
			inFull_nxt = 1'b1;
			irqStat_nxt[scp_pkg::EVT_WRITTEN] = 1'b1;
			if (inFull_r) begin
				inOvf_nxt = 1'b1;
				irqStat_nxt[scp_pkg::EVT_OVF] = 1'b1;
			end
		end
		if (rdEvt) begin
			outFull_nxt = wrAcc && idx == scp_pkg::IDX_DATA_LATCH
				&& mode_r;
			irqStat_nxt[scp_pkg::EVT_READ] = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			outLatch_r <= scp_pkg::RST_LATCH;
			inLatch_r <= scp_pkg::RST_LATCH;
			dataDir_r <= scp_pkg::RST_DATA_DIR;
			ctrlDir_r <= scp_pkg::RST_CTRL_DIR;
			ctrlOut_r <= 3'h0;
			analog_r <= scp_pkg::RST_ANALOG;
			mode_r <= 1'b0;
			inFull_r <= 1'b0;
			outFull_r <= 1'b0;
			inOvf_r <= 1'b0;
			irqStat_r <= 3'h0;
			irqMask_r <= 3'h0;
			rdData_r <= 32'h0000_0000;
			errHit_r <= 1'b0;
		end else begin
			outLatch_r <= outLatch_nxt;
			inLatch_r <= inLatch_nxt;
			dataDir_r <= dataDir_nxt;
			ctrlDir_r <= ctrlDir_nxt;
			ctrlOut_r <= ctrlOut_nxt;
			analog_r <= analog_nxt;
			mode_r <= mode_nxt;
			inFull_r <= inFull_nxt;
			outFull_r <= outFull_nxt;
			inOvf_r <= inOvf_nxt;
			irqStat_r <= irqStat_nxt;
			irqMask_r <= irqMask_nxt;
			rdData_r <= rdData_nxt;
			errHit_r <= errHit_nxt;
		end
	end

	// ************************************************************
	// Pin drive and bus answers.
	// ************************************************************
	// Direction bits steer the control pins in every mode, analog
	// included; slave mode relies on software leaving them inputs.
	assign link.ctrlDevOe = ~ctrlDir_r;
	assign link.ctrlDevOut = ctrlOut_r;
	assign link.dataDevOut = outLatch_r;
	// In slave mode the bus is driven only while a read is decoded.
	assign link.dataDevOe = mode_r ? {8{rdAct}} : ~dataDir_r;

	assign prdata = rdData_r;
	assign pready = 1'b1;
	assign pslverr = access && errHit_r;
	assign irq = |(irqStat_r & irqMask_r);

endmodule

/* File: bench/scp_assertions.sv */
// Checker for the pin link between the two ends of the slave control port.
`timescale 1ns/100ps
module scp_assertions (
	input wire logic clock,
	input wire logic srst,
	input wire logic [2:0] ctrlLevel,
	input wire logic [2:0] ctrlDevOe,
	input wire logic [7:0] dataDevOe,
	input wire logic [2:0] ctrlHostOut,
	input wire logic [2:0] ctrlHostOe,
	input wire logic [7:0] dataHostOe
);
	// ************************************************************
	// Link properties; the strobe length assumes eight cycles.
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// A strobe stays low for its full length, then rises.
	sequence writeHeld;
		!ctrlHostOut[1] [*8] ##1 ctrlHostOut[1];
	endsequence
	sequence readHeld;
		!ctrlHostOut[0] [*8] ##1 ctrlHostOut[0];
	endsequence

	chk_reset_dirs_input: assert property (
		$fell(srst) |-> ctrlDevOe == 3'h0) else $error("dirs not input");
	chk_host_idle_reset: assert property (
		$fell(srst) |-> ctrlHostOut == 3'h7 && dataHostOe == 8'h00)
		else $error("host not idle after reset");
	chk_write_width: assert property (
		$fell(ctrlHostOut[1]) |-> writeHeld) else $error("write strobe length");
	chk_read_width: assert property (
		$fell(ctrlHostOut[0]) |-> readHeld) else $error("read strobe length");
	chk_select_first: assert property (
		($fell(ctrlHostOut[1]) || $fell(ctrlHostOut[0]))
		|-> $past(ctrlHostOut[2]) == 1'b0) else $error("strobe before select");
	chk_select_gap: assert property (
		$rose(ctrlHostOut[2]) |-> ctrlHostOut[2] [*4])
		else $error("select gap too short");
	chk_write_data_on: assert property (
		!ctrlHostOut[1] |-> dataHostOe == 8'hff && ctrlHostOe == 3'h7)
		else $error("write data not driven");
	chk_no_bus_fight: assert property (
		(|dataDevOe) |-> !(|dataHostOe)) else $error("both ends drive data");
	chk_drive_needs_cs: assert property (
		(|dataDevOe) |-> !$past(ctrlLevel[2], 2) || !$past(ctrlLevel[2], 3))
		else $error("data driven without select");
	chk_release_deselect: assert property (
		ctrlLevel[2] [*3] |=> dataDevOe == 8'h00)
		else $error("data driven after deselect");
endmodule

/* File: bench/test_slave_port_control_pins.sv */
// Self-checking bench joining the device end and the host end.
`timescale 1ns/100ps
module test_slave_port_control_pins;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [scp_pkg::ADDR_W-1:0] paddr = 12'h000;
	logic [scp_pkg::DATA_W-1:0] pwdata = 32'h0;
	logic [scp_pkg::DATA_W-1:0] prdata;
	logic pready, pslverr, irq, reqReady, rspValid;
	logic reqValid = 1'b0;
	logic reqWrite = 1'b0;
	logic [7:0] reqData = 8'h00;
	logic [7:0] rspData, b1, b2, b3, b4;
	logic [31:0] seed = 32'h63fa;
	logic [32:0] apbQ[$];
	logic [7:0] hostQ[$];
	int bad_count = 0;
	int checked = 0;

	// Free-running 100 MHz clock.
	always #5 clock = ~clock;

	scp_link_if link_i();
	scp_device_end scp_device_end_i (.clock(clock), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .link(link_i));
	scp_host_end #(.STROBE_CYCLES(8), .GAP_CYCLES(3)) scp_host_end_i (
		.clock(clock), .srst(srst), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqData(reqData), .reqReady(reqReady),
		.rspValid(rspValid), .rspData(rspData), .link(link_i));
	scp_assertions scp_assertions_i (.clock(clock), .srst(srst),
		.ctrlLevel(link_i.ctrlLevel), .ctrlDevOe(link_i.ctrlDevOe),
		.dataDevOe(link_i.dataDevOe), .ctrlHostOut(link_i.ctrlHostOut),
		.ctrlHostOe(link_i.ctrlHostOe), .dataHostOe(link_i.dataHostOe));

	// ************************************************************
	// Helpers.
	// ************************************************************
	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic chk(input logic [32:0] got, input logic [32:0] exp,
		input string m);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s: got %h, expected %h", $time, m, got, exp);
		end
	endtask

	// One APB transfer; only the watchdog may end a wait for pready.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] idx, input logic [7:0] e);
		apbQ.push_back({9'h0, 16'h0, e});
		apb(1'b0, {idx, 2'b00}, 32'h0);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, {idx, 2'b00}, {24'h0, d});
	endtask

	// One host transfer, returning once the host is idle again.
	task automatic host(input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqData <= d;
		@(posedge clock);
		reqValid <= 1'b0;
		do begin
			@(posedge clock);
			n++;
		end while (reqReady !== 1'b1 && n < 100);
		if (n >= 100) begin
			bad_count++;
			$display("[ERR] %0t host stuck", $time);
			complete_run();
		end
	endtask

	task complete_run;
		$display("checked %0d, bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Takes the oldest note whenever a read result appears.
	always @(posedge clock) begin
		if (psel && penable && pready && !pwrite && apbQ.size() > 0)
			chk({pslverr, prdata}, apbQ.pop_front(), "apb read");
		if (rspValid === 1'b1 && hostQ.size() > 0)
			chk({25'h0, rspData}, {25'h0, hostQ.pop_front()}, "host read");
	end

	// Watchdog: the sequence needs well under a tenth of this span.
	initial begin
		#100000;
		bad_count++;
		complete_run();
	end

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial begin
		b1 = rnd8();
		b2 = rnd8();
		b3 = rnd8();
		b4 = rnd8();
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		rd(scp_pkg::IDX_DIR_STATUS, 8'h07);
		rd(scp_pkg::IDX_ANALOG_CFG, 8'h07);
		rd(scp_pkg::IDX_DATA_DIR, scp_pkg::RST_DATA_DIR);
		rd(scp_pkg::IDX_CTRL_PORT, 8'h00);
		apbQ.push_back({1'b1, 32'h0});
		apb(1'b0, 12'h3fc, 32'h0);
		wr(scp_pkg::IDX_ANALOG_CFG, 8'h00);
		rd(scp_pkg::IDX_CTRL_PORT, 8'h07);
		wr(scp_pkg::IDX_DIR_STATUS, 8'h00);
		wr(scp_pkg::IDX_CTRL_PORT, 8'h05);
		// The driven level reaches the read mux only through two flops.
		repeat (2) @(posedge clock);
		rd(scp_pkg::IDX_CTRL_PORT, 8'h05);
		wr(scp_pkg::IDX_ANALOG_CFG, 8'h07);
		chk({30'h0, link_i.ctrlDevOe}, 33'h7, "analog dir");
		rd(scp_pkg::IDX_CTRL_PORT, 8'h00);
		wr(scp_pkg::IDX_ANALOG_CFG, 8'h00);
		wr(scp_pkg::IDX_DIR_STATUS, 8'h07);
		host(1'b1, b1);
		rd(scp_pkg::IDX_DIR_STATUS, 8'h07);
		wr(scp_pkg::IDX_IRQ_MASK, 8'h07);
		wr(scp_pkg::IDX_DIR_STATUS, 8'h17);
		rd(scp_pkg::IDX_DIR_STATUS, 8'h17);
		host(1'b1, b1);
		rd(scp_pkg::IDX_DIR_STATUS, 8'h97);
		chk({32'h0, irq}, 33'h1, "irq raised");
		rd(scp_pkg::IDX_IRQ_STATUS, 8'h01);
		rd(scp_pkg::IDX_DATA_LATCH, b1);
		chk({32'h0, irq}, 33'h0, "irq cleared");
		rd(scp_pkg::IDX_DIR_STATUS, 8'h17);
		host(1'b1, b2);
		host(1'b1, b3);
		rd(scp_pkg::IDX_DIR_STATUS, 8'hb7);
		wr(scp_pkg::IDX_DIR_STATUS, 8'h37);
		rd(scp_pkg::IDX_DIR_STATUS, 8'hb7);
		wr(scp_pkg::IDX_DIR_STATUS, 8'h17);
		rd(scp_pkg::IDX_DIR_STATUS, 8'h97);
		rd(scp_pkg::IDX_IRQ_STATUS, 8'h05);
		wr(scp_pkg::IDX_IRQ_MASK, 8'h00);
		wr(scp_pkg::IDX_DATA_LATCH, b4);
		rd(scp_pkg::IDX_DIR_STATUS, 8'hd7);
		hostQ.push_back(b4);
		host(1'b0, 8'h00);
		rd(scp_pkg::IDX_DIR_STATUS, 8'h97);
		chk({32'h0, irq}, 33'h0, "irq masked");
		rd(scp_pkg::IDX_IRQ_STATUS, 8'h02);
		@(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd(scp_pkg::IDX_DIR_STATUS, 8'h07);
		rd(scp_pkg::IDX_ANALOG_CFG, 8'h07);
		repeat (4) @(posedge clock);
		complete_run();
	end
endmodule
